// >>> core/thermal_trip_map.svh
// Register pointers, field positions, reset values and hysteresis steps
`ifndef THERMAL_TRIP_MAP_SVH
`define THERMAL_TRIP_MAP_SVH

`define PTR_W 8
`define PTR_UPPER 8'h02
`define PTR_LOWER 8'h03
`define PTR_CRIT 8'h04
`define PTR_TEMP 8'h05
`define PTR_MAKER 8'h06
`define PTR_PART 8'h07

`define WORD_W 16
`define WORD_ZERO 16'h0000
`define LIMIT_MSB 12
`define LIMIT_LSB 2
`define LIMIT_W 11
`define LIMIT_ZERO 11'h000
`define TEMP_MSB 12
`define TEMP_LSB 1
`define TEMP_W 12
`define TEMP_ZERO 12'h000
`define BIT_CRIT 15
`define BIT_ABOVE 14
`define BIT_BELOW 13

`define EXT_W 14
`define HYST_SEL_W 2
`define HYST_OFF 14'h0000
`define HYST_1P5 14'h000C
`define HYST_3 14'h0018
`define HYST_6 14'h0030
`define HYST_SEL_OFF 2'h0
`define HYST_SEL_1P5 2'h1
`define HYST_SEL_3 2'h2
`define HYST_SEL_6 2'h3

`endif

// >>> core/thermal_trip_pkg.sv
// Types shared by the trip register bank and its comparators
package thermal_trip_pkg;
	typedef enum {TRIP_BELOW, TRIP_ABOVE, TRIP_CRIT} trip_kind_t;
	typedef logic signed [13:0] temp_ext_t;
	typedef logic [15:0] reg_word_t;
endpackage : thermal_trip_pkg

// >>> core/thermal_trip_register_bank.sv
// Threshold, temperature and identification registers with trip flags
`timescale 1ns/1ps
`include "thermal_trip_map.svh"
module thermal_trip_register_bank
	import thermal_trip_pkg::*;
#(
	parameter logic [`WORD_W-1:0] MAKER_CODE = 16'h5A5A, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value
)
(
	input wire logic sys_clk_i, // System clock, 125 MHz
	input wire logic nrst_i, // Power-on reset, sync, active low
	input wire logic [`PTR_W-1:0] reg_ptr_i, // Register pointer
	input wire logic wr_stb_i, // Register write strobe
	input wire logic [`WORD_W-1:0] wr_data_i, // Register write data
	input wire logic rd_stb_i, // Register read strobe
	output logic [`WORD_W-1:0] rd_data_o, // Register read data
	output logic rd_valid_o, // Read data valid pulse
	output logic wr_refused_o, // Write ignored pulse
	input wire logic [`HYST_SEL_W-1:0] hyst_sel_i, // Hysteresis select
	input wire logic alarm_lock_i, // Alarm window lock
	input wire logic crit_lock_i, // Critical limit lock
	input wire logic sample_stb_i, // New temperature sample
	input wire logic [`TEMP_W-1:0] sample_i, // Sample, eighth degrees
	output logic [`WORD_W-1:0] temp_word_o, // Temperature register
	output logic above_crit_o, // At or above critical
	output logic above_window_o, // Above alarm window
	output logic below_window_o, // Below alarm window
	output logic in_window_o // Inside alarm window
);
	logic [`LIMIT_W-1:0] upper_q;
	logic [`LIMIT_W-1:0] lower_q;
	logic [`LIMIT_W-1:0] crit_q;
	logic [`TEMP_W-1:0] temp_q;
	logic [`EXT_W-1:0] hyst_c;
	logic above_win_d;
	logic below_win_d;
	logic sel_upper;
	logic sel_lower;
	logic sel_crit;
	logic sel_temp;
	logic sel_maker;
	logic sel_part;
	logic wr_upper;
	logic wr_lower;
	logic wr_crit;
	logic wr_refused_d;
	logic [`LIMIT_W-1:0] wr_limit;
	reg_word_t temp_word_c;
	reg_word_t rd_word_c;

	// Pointer decode
	assign sel_upper = reg_ptr_i == `PTR_UPPER;
	assign sel_lower = reg_ptr_i == `PTR_LOWER;
	assign sel_crit = reg_ptr_i == `PTR_CRIT;
	assign sel_temp = reg_ptr_i == `PTR_TEMP;
	assign sel_maker = reg_ptr_i == `PTR_MAKER;
	assign sel_part = reg_ptr_i == `PTR_PART;

	// Only the signed quarter-degree field is kept
	assign wr_limit = wr_data_i[`LIMIT_MSB:`LIMIT_LSB];

	// Locked boundaries drop the write
	assign wr_upper = wr_stb_i && sel_upper && !alarm_lock_i;
	assign wr_lower = wr_stb_i && sel_lower && !alarm_lock_i;
	assign wr_crit = wr_stb_i && sel_crit && !crit_lock_i;

	always_comb
	begin
		wr_refused_d = 1'b0;
		if (wr_stb_i)
		begin
			if ((sel_upper || sel_lower) && alarm_lock_i)
				wr_refused_d = 1'b1;
			else if (sel_crit && crit_lock_i)
				wr_refused_d = 1'b1;
			else if (sel_temp || sel_maker || sel_part)
				wr_refused_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			upper_q <= `LIMIT_ZERO;
		else if (wr_upper)
			upper_q <= wr_limit;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			lower_q <= `LIMIT_ZERO;
		else if (wr_lower)
			lower_q <= wr_limit;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			crit_q <= `LIMIT_ZERO;
		else if (wr_crit)
			crit_q <= wr_limit;
	end

	// Sample latch; host writes never reach it
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			temp_q <= `TEMP_ZERO;
		else if (sample_stb_i)
			temp_q <= sample_i;
	end

	// Hysteresis in eighth-degree steps
	always_comb
	begin
		case (hyst_sel_i)
			`HYST_SEL_OFF: hyst_c = `HYST_OFF;
			`HYST_SEL_1P5: hyst_c = `HYST_1P5;
			`HYST_SEL_3: hyst_c = `HYST_3;
			`HYST_SEL_6: hyst_c = `HYST_6;
			default: hyst_c = `HYST_OFF;
		endcase
	end

	// Flags see only sample, limits and hysteresis
	trip_flag #(
		.KIND(TRIP_BELOW)
	) u_below (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.sample_stb_i(sample_stb_i),
		.temp_i(sample_i),
		.limit_i(lower_q),
		.hyst_i(hyst_c),
		.flag_o(below_window_o),
		.flag_d_o(below_win_d)
	);

	trip_flag #(
		.KIND(TRIP_ABOVE)
	) u_above (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.sample_stb_i(sample_stb_i),
		.temp_i(sample_i),
		.limit_i(upper_q),
		.hyst_i(hyst_c),
		.flag_o(above_window_o),
		.flag_d_o(above_win_d)
	);

	trip_flag #(
		.KIND(TRIP_CRIT)
	) u_crit (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.sample_stb_i(sample_stb_i),
		.temp_i(sample_i),
		.limit_i(crit_q),
		.hyst_i(hyst_c),
		.flag_o(above_crit_o),
		.flag_d_o()
	);

	// Window state follows the flags in the same cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			in_window_o <= 1'b1;
		else
			in_window_o <= !above_win_d && !below_win_d;
	end

	// Temperature register image
	always_comb
	begin
		temp_word_c = `WORD_ZERO;
		temp_word_c[`TEMP_MSB:`TEMP_LSB] = temp_q;
		temp_word_c[`BIT_CRIT] = above_crit_o;
		temp_word_c[`BIT_ABOVE] = above_window_o;
		temp_word_c[`BIT_BELOW] = below_window_o;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			temp_word_o <= `WORD_ZERO;
		else
			temp_word_o <= temp_word_c;
	end

	// Read multiplexer; unused bits and pointers read zero
	always_comb
	begin
		rd_word_c = `WORD_ZERO;
		case (reg_ptr_i)
			`PTR_UPPER:
			begin
				rd_word_c[`LIMIT_MSB:`LIMIT_LSB] = upper_q;
			end
			`PTR_LOWER:
			begin
				rd_word_c[`LIMIT_MSB:`LIMIT_LSB] = lower_q;
			end
			`PTR_CRIT:
			begin
				rd_word_c[`LIMIT_MSB:`LIMIT_LSB] = crit_q;
			end
			`PTR_TEMP:
			begin
				rd_word_c = temp_word_c;
			end
			`PTR_MAKER:
			begin
				rd_word_c = MAKER_CODE;
			end
			`PTR_PART:
			begin
				rd_word_c = {PART_CODE, REVISION_CODE};
			end
			default:
			begin
				rd_word_c = `WORD_ZERO;
			end
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			rd_data_o <= `WORD_ZERO;
		else if (rd_stb_i)
			rd_data_o <= rd_word_c;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			rd_valid_o <= 1'b0;
		else
			rd_valid_o <= rd_stb_i;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			wr_refused_o <= 1'b0;
		else
			wr_refused_o <= wr_refused_d;
	end
endmodule : thermal_trip_register_bank

// >>> core/trip_flag.sv
// One hysteresis trip comparator and its flag
`timescale 1ns/1ps
`include "thermal_trip_map.svh"
module trip_flag
	import thermal_trip_pkg::*;
#(
	parameter trip_kind_t KIND = TRIP_CRIT
)
(
	input wire logic sys_clk_i, // System clock
	input wire logic nrst_i, // Sync reset, active low
	input wire logic sample_stb_i, // New sample this cycle
	input wire logic [`TEMP_W-1:0] temp_i, // Sample, eighth degrees
	input wire logic [`LIMIT_W-1:0] limit_i, // Limit, quarter degrees
	input wire logic [`EXT_W-1:0] hyst_i, // Hysteresis, eighth degrees
	output logic flag_o, // Trip flag
	output logic flag_d_o // Trip flag next value
);
	temp_ext_t t;
	temp_ext_t l;
	temp_ext_t lh;
	logic set_c;
	logic clr_c;

	// Limit scaled to eighth degrees; sample and limit sign extended, hysteresis cast at full width
	assign t = temp_ext_t'($signed(temp_i));
	assign l = temp_ext_t'($signed({limit_i, 1'b0}));
	assign lh = l - temp_ext_t'(hyst_i);

	always_comb
	begin
		set_c = 1'b0;
		clr_c = 1'b0;
		case (KIND)
			TRIP_BELOW:
			begin
				set_c = t < lh;
				clr_c = t >= l;
			end
			TRIP_ABOVE:
			begin
				set_c = t > l;
				clr_c = t <= lh;
			end
			TRIP_CRIT:
			begin
				set_c = t >= l;
				clr_c = t < lh;
			end
			default:
			begin
				set_c = 1'b0;
				clr_c = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		flag_d_o = flag_o;
		if (sample_stb_i)
		begin
			if (set_c)
				flag_d_o = 1'b1;
			else if (clr_c)
				flag_d_o = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (!nrst_i)
			flag_o <= 1'b0;
		else
			flag_o <= flag_d_o;
	end
endmodule : trip_flag

// >>> tb/host_model.sv
// Host side model issuing register reads and writes
`timescale 1ns/1ps
module host_model
(
	input wire logic sys_clk_i, // Clock
	input wire logic [15:0] rd_data_i, // Read data
	input wire logic rd_valid_i, // Read valid
	output logic [7:0] reg_ptr_o = 8'h00, // Pointer
	output logic wr_stb_o = 1'b0, // Write strobe
	output logic [15:0] wr_data_o = 16'h0000, // Write data
	output logic rd_stb_o = 1'b0 // Read strobe
);
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		@(posedge sys_clk_i) #1;
		reg_ptr_o = p;
		wr_data_o = d;
		wr_stb_o = 1'b1;
		@(posedge sys_clk_i) #1;
		wr_stb_o = 1'b0;
		// Released data no longer shows the last word
		wr_data_o = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic v);
		@(posedge sys_clk_i) #1;
		reg_ptr_o = p;
		rd_stb_o = 1'b1;
		@(posedge sys_clk_i) #1;
		rd_stb_o = 1'b0;
		d = rd_data_i;
		v = rd_valid_i;
	endtask : rd
endmodule : host_model

// >>> tb/tb_thermal_trip_register_bank.sv
// Self-checking bench of the trip register bank
`timescale 1ns/1ps
module tb_thermal_trip_register_bank;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] reg_ptr_i;
	logic wr_stb_i, rd_stb_i, rd_valid_o, wr_refused_o, sample_stb_i = 1'b0;
	logic [15:0] wr_data_i, rd_data_o, temp_word_o;
	logic [1:0] hyst_sel_i = 2'h0;
	logic alarm_lock_i = 1'b0;
	logic crit_lock_i = 1'b0;
	logic [11:0] sample_i = 12'h000;
	logic above_crit_o, above_window_o, below_window_o, in_window_o;
	logic [11:0] hv [4] = '{12'h000, 12'h00C, 12'h018, 12'h030};
	logic [11:0] ts [8] = '{12'h100, 12'h320, 12'h309, 12'h307, 12'h09F, 12'h087, 12'h0A0, 12'hF00};
	logic [2:0] fs [8] = '{3'h0, 3'h6, 3'h6, 3'h2, 3'h0, 3'h1, 3'h0, 3'h1};
	int n_errors = 0;
	int n_compared = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	// Arbitrary identity values
	thermal_trip_register_bank #(.MAKER_CODE(16'h1234), .PART_CODE(8'hA5), .REVISION_CODE(8'h02))
		thermal_trip_register_bank_i (.sys_clk_i, .nrst_i, .reg_ptr_i, .wr_stb_i, .wr_data_i,
		.rd_stb_i, .rd_data_o, .rd_valid_o, .wr_refused_o, .hyst_sel_i, .alarm_lock_i,
		.crit_lock_i, .sample_stb_i, .sample_i, .temp_word_o, .above_crit_o,
		.above_window_o, .below_window_o, .in_window_o);
	host_model host_model_i (.sys_clk_i(sys_clk_i), .rd_data_i(rd_data_o),
		.rd_valid_i(rd_valid_o), .reg_ptr_o(reg_ptr_i), .wr_stb_o(wr_stb_i),
		.wr_data_o(wr_data_i), .rd_stb_o(rd_stb_i));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
		logic [15:0] d;
		logic v;
		host_model_i.rd(p, d, v);
		check({15'h0000, v}, 16'h0001);
		check(d, exp);
	endtask : rd_chk
	task automatic wr_chk(input logic [7:0] p, input logic [15:0] d, input logic r);
		host_model_i.wr(p, d);
		check({15'h0000, wr_refused_o}, {15'h0000, r});
	endtask : wr_chk
	task automatic smp(input logic [11:0] t, input logic [2:0] f);
		@(posedge sys_clk_i) #1;
		sample_i = t;
		sample_stb_i = 1'b1;
		@(posedge sys_clk_i) #1;
		sample_stb_i = 1'b0;
		check({12'h000, above_crit_o, above_window_o, below_window_o, in_window_o},
			{12'h000, f, f[1:0] == 2'h0});
		rd_chk(8'h05, {f, t, 1'b0});
		check(temp_word_o, {f, t, 1'b0});
	endtask : smp
	task automatic print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		#100000;
		n_errors++;
		print_verdict();
	end
	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		#1;
		nrst_i = 1'b1;
		for (int p = 2; p < 6; p++) rd_chk(8'(p), 16'h0000);
		rd_chk(8'h06, 16'h1234);
		rd_chk(8'h07, 16'hA502);
		rd_chk(8'h00, 16'h0000);
		wr_chk(8'h02, 16'hFFFF, 1'b0);
		rd_chk(8'h02, 16'h1FFC);
		wr_chk(8'h03, 16'h1000, 1'b0);
		rd_chk(8'h03, 16'h1000);
		wr_chk(8'h04, 16'h0FFC, 1'b0);
		rd_chk(8'h04, 16'h0FFC);
		for (int p = 5; p < 8; p++) wr_chk(8'(p), 16'hFFFF, 1'b1);
		rd_chk(8'h05, 16'h0000);
		rd_chk(8'h07, 16'hA502);
		// Upper 80, lower 20, critical 100 degrees, field in bits 12..2
		wr_chk(8'h02, 16'h0500, 1'b0);
		wr_chk(8'h03, 16'h0140, 1'b0);
		wr_chk(8'h04, 16'h0640, 1'b0);
		alarm_lock_i = 1'b1;
		crit_lock_i = 1'b1;
		wr_chk(8'h03, 16'h0000, 1'b1);
		wr_chk(8'h04, 16'h0000, 1'b1);
		rd_chk(8'h03, 16'h0140);
		rd_chk(8'h04, 16'h0640);
		// Locks stay set: flags must not care
		for (int s = 0; s < 4; s++)
		begin
			hyst_sel_i = 2'(s);
			smp(12'h281, 3'h2);
			smp(12'h281 - hv[s], 3'h2);
			smp(12'h280 - hv[s], 3'h0);
		end
		hyst_sel_i = 2'h2;
		for (int i = 0; i < 8; i++) smp(ts[i], fs[i]);
		// Mid-run reset; the locks fall with it
		nrst_i = 1'b0;
		alarm_lock_i = 1'b0;
		crit_lock_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		nrst_i = 1'b1;
		check({12'h000, above_crit_o, above_window_o, below_window_o, in_window_o}, 16'h0001);
		check(temp_word_o, 16'h0000);
		for (int p = 2; p < 6; p++) rd_chk(8'(p), 16'h0000);
		wr_chk(8'h03, 16'h0140, 1'b0);
		rd_chk(8'h03, 16'h0140);
		print_verdict();
	end
endmodule : tb_thermal_trip_register_bank

// >>> tb/trip_bank_checker_properties.sv
// Checker of access pulses and trip flag relations
`timescale 1ns/1ps
`include "thermal_trip_map.svh"
module trip_bank_checker
(
	input wire logic sys_clk_i, // Clock
	input wire logic nrst_i, // Reset
	input wire logic [`PTR_W-1:0] reg_ptr_i, // Pointer
	input wire logic wr_stb_i, // Write
	input wire logic rd_stb_i, // Read
	input wire logic alarm_lock_i, // Lock
	input wire logic crit_lock_i, // Critical lock
	input wire logic sample_stb_i, // Sample
	input wire logic [`TEMP_W-1:0] sample_i, // Sample value
	input wire logic rd_valid_o, // Valid
	input wire logic wr_refused_o, // Refused
	input wire logic [`WORD_W-1:0] temp_word_o, // Image
	input wire logic above_crit_o, // Flag
	input wire logic above_window_o, // Flag
	input wire logic below_window_o, // Flag
	input wire logic in_window_o // Flag
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_sample;
		sample_stb_i ##1 1'b1;
	endsequence
	property p_rd_valid; rd_stb_i |=> rd_valid_o; endproperty
	property p_rd_quiet; !rd_stb_i |=> !rd_valid_o; endproperty
	property p_ro_refused;
		wr_stb_i && reg_ptr_i inside {`PTR_TEMP, `PTR_MAKER, `PTR_PART} |=> wr_refused_o;
	endproperty
	property p_alarm_lock;
		wr_stb_i && alarm_lock_i && reg_ptr_i inside {`PTR_UPPER, `PTR_LOWER} |=> wr_refused_o;
	endproperty
	property p_crit_lock;
		wr_stb_i && crit_lock_i && reg_ptr_i == `PTR_CRIT |=> wr_refused_o;
	endproperty
	property p_window; in_window_o == !(above_window_o || below_window_o); endproperty
	property p_temp_image;
		s_sample |=> temp_word_o[12:1] == $past(sample_i, 2) && !temp_word_o[0];
	endproperty
	property p_flag_image;
		1'b1 |=> temp_word_o[15:13] == $past({above_crit_o, above_window_o, below_window_o});
	endproperty
	property p_flag_hold;
		!sample_stb_i |=> $stable({above_crit_o, above_window_o, below_window_o});
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
	a_ro_refused: assert property (p_ro_refused) else $error("read-only write taken");
	a_alarm_lock: assert property (p_alarm_lock) else $error("locked write taken");
	a_crit_lock: assert property (p_crit_lock) else $error("locked critical write taken");
	a_window: assert property (p_window) else $error("window flag wrong");
	a_temp_image: assert property (p_temp_image) else $error("temp image wrong");
	a_flag_image: assert property (p_flag_image) else $error("flag image wrong");
	a_flag_hold: assert property (p_flag_hold) else $error("flags moved");
endmodule : trip_bank_checker
bind thermal_trip_register_bank trip_bank_checker trip_bank_checker_i (.sys_clk_i(sys_clk_i),
	.nrst_i(nrst_i), .reg_ptr_i(reg_ptr_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
	.alarm_lock_i(alarm_lock_i), .crit_lock_i(crit_lock_i), .sample_stb_i(sample_stb_i),
	.sample_i(sample_i),
	.rd_valid_o(rd_valid_o), .wr_refused_o(wr_refused_o), .temp_word_o(temp_word_o),
	.above_crit_o(above_crit_o), .above_window_o(above_window_o),
	.below_window_o(below_window_o), .in_window_o(in_window_o));
